// [hw/utx_pkg.sv]
package utx_pkg;

	localparam int DATA_W      = 8;
	localparam int ADDR_W      = 5;
	localparam int UPPER_LO    = 5;
	localparam int UPPER_W     = 3;
	localparam int SYNC_STAGES = 2;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 5'h00;
	localparam logic [ADDR_W-1:0] ADDR_LAST = 5'h1f;

	// link timing: one-clock strobe, answer one link clock after address
	localparam int CLAV_LAG_EDGES = 1;

	typedef struct packed {
		logic [UPPER_W-1:0] data_hi;
		logic [ADDR_W-1:0]  addr;
		logic               addr_oe;
		logic               data_oe;
	} utx_tx_pins_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              space;
		logic              valid;
	} utx_poll_t;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_POLL   = 4'b0010,
		ST_SELECT = 4'b0100,
		ST_SEND   = 4'b1000
	} utx_state_t;

endpackage

// [hw/utx_port.sv]
module utx_port (
	input  wire logic                          mclk,            // system clock 250 mhz
	input  wire logic                          rst,             // async reset, high
	input  wire logic                          mode_cell,       // 1 = cell mode, 0 = mii
	input  wire logic                          multi_phy,       // 1 = multi-phy polling
	input  wire logic                          cell_tx_clock,   // link transmit clock pin
	input  wire logic                          cell_rx_clock,   // receive / mii clock pin
	input  wire logic [utx_pkg::DATA_W-1:0]    cell_tx_byte,    // byte to send
	input  wire logic                          cell_go,         // request to select a phy
	input  wire logic [utx_pkg::ADDR_W-1:0]    cell_target,     // phy wanted for next cell
	input  wire logic                          cell_done,       // cell finished, deselect
	input  wire logic                          tx_cell_space_flag, // shared clav pin
	input  wire logic [utx_pkg::DATA_W-1:0]    rx_pin_bus,      // raw receive inputs
	output utx_pkg::utx_tx_pins_t              tx_pins,         // upper data and address
	output logic                               tx_enable_strobe,// active-high select strobe
	output utx_pkg::utx_poll_t                 poll_result,     // latest clav sample
	output logic [utx_pkg::DATA_W-1:0]         rx_sampled,      // inputs at rx rising edge
	output logic                               rx_sample_pulse  // one mclk per rx edge
);

	// =====================================================
	// link clock synchronisers and edge detection
	logic [utx_pkg::SYNC_STAGES-1:0] txc_sync;
	logic [utx_pkg::SYNC_STAGES-1:0] rxc_sync;
	logic [utx_pkg::SYNC_STAGES-1:0] clav_sync;
	logic                            txc_prev;
	logic                            rxc_prev;
	logic                            tx_rise;
	logic                            rx_rise;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			txc_sync  <= '0;
			rxc_sync  <= '0;
			clav_sync <= '0;
			txc_prev  <= 1'b0;
			rxc_prev  <= 1'b0;
		end else begin
			txc_sync  <= {txc_sync[0], cell_tx_clock};
			rxc_sync  <= {rxc_sync[0], cell_rx_clock};
			clav_sync <= {clav_sync[0], tx_cell_space_flag};
			txc_prev  <= txc_sync[1];
			rxc_prev  <= rxc_sync[1];
		end
	end

	assign tx_rise = txc_sync[1] & ~txc_prev;
	assign rx_rise = rxc_sync[1] & ~rxc_prev;

	// =====================================================
	// receive sampling; raw bus passes two flops, read only at rx edges
	// no address filter here: frames go up unfiltered
	logic [utx_pkg::DATA_W-1:0] rx_s1;
	logic [utx_pkg::DATA_W-1:0] rx_s2;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rx_s1           <= '0;
			rx_s2           <= '0;
			rx_sampled      <= '0;
			rx_sample_pulse <= 1'b0;
		end else begin
			rx_s1           <= rx_pin_bus;
			rx_s2           <= rx_s1;
			rx_sample_pulse <= rx_rise;
			if (rx_rise) begin
				rx_sampled <= rx_s2;
			end
		end
	end

	// =====================================================
	// transmit sequencer: walk poll addresses, select, send
	utx_pkg::utx_state_t         state;
	logic [utx_pkg::ADDR_W-1:0]  poll_addr;
	logic [utx_pkg::ADDR_W-1:0]  next_addr;
	logic                        next_strobe;

	always_comb begin
		next_addr   = poll_addr;
		next_strobe = 1'b0;
		case (state)
			utx_pkg::ST_SELECT: begin
				next_addr   = cell_target;
				// no strobe with the address pins released: a floating bus picks any phy
				next_strobe = mode_cell && multi_phy;
			end
			default: begin
				next_addr = poll_addr;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state     <= utx_pkg::ST_IDLE;
			poll_addr <= utx_pkg::ADDR_ZERO;
		end else if (tx_rise) begin
			case (state)
				utx_pkg::ST_IDLE: begin
					if (mode_cell && multi_phy) begin
						state <= utx_pkg::ST_POLL;
					end
				end
				utx_pkg::ST_POLL: begin
					if (!(mode_cell && multi_phy)) begin
						state <= utx_pkg::ST_IDLE;
					end else if (cell_go) begin
						state <= utx_pkg::ST_SELECT;
					end else begin
						// wraps after the last address, so every phy is polled in turn
						poll_addr <= poll_addr + 5'h01;
					end
				end
				utx_pkg::ST_SELECT: begin
					state <= utx_pkg::ST_SEND; // one link clock of strobe
				end
				utx_pkg::ST_SEND: begin
					if (cell_done) begin
						state <= utx_pkg::ST_POLL;
					end
				end
				default: begin
					state <= utx_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// outputs change only at transmit clock rising edges
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tx_pins          <= '0;
			tx_enable_strobe <= 1'b0;
		end else if (tx_rise) begin
			tx_pins.data_hi  <= cell_tx_byte[utx_pkg::UPPER_LO +: utx_pkg::UPPER_W];
			tx_pins.data_oe  <= mode_cell;
			tx_pins.addr     <= next_addr;
			tx_pins.addr_oe  <= mode_cell && multi_phy;
			tx_enable_strobe <= next_strobe;
		end
	end

	// =====================================================
	// clav capture: sample at link edge belongs to previous address
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			poll_result <= '0;
		end else if (tx_rise) begin
			poll_result.addr  <= tx_pins.addr;
			poll_result.space <= clav_sync[1];
			poll_result.valid <= tx_pins.addr_oe;
		end
	end

	// =====================================================
	// checks
	a_upper_data: assert property (@(posedge mclk) disable iff (rst)
		tx_rise |=> tx_pins.data_hi == $past(cell_tx_byte[utx_pkg::UPPER_LO +: utx_pkg::UPPER_W]))
		else $error("upper data bits not the top of the byte");
	a_data_oe_mode: assert property (@(posedge mclk) disable iff (rst)
		tx_rise |=> tx_pins.data_oe == $past(mode_cell))
		else $error("data enable wrong for mode");
	a_addr_stable: assert property (@(posedge mclk) disable iff (rst)
		!tx_rise |=> $stable(tx_pins.addr))
		else $error("address moved off transmit edge");
	a_strobe_off_edge: assert property (@(posedge mclk) disable iff (rst)
		!tx_rise |=> $stable(tx_enable_strobe))
		else $error("strobe moved off transmit edge");
	a_strobe_one: assert property (@(posedge mclk) disable iff (rst)
		$rose(tx_enable_strobe) |-> state == utx_pkg::ST_SEND)
		else $error("strobe without select");
	a_strobe_width: assert property (@(posedge mclk) disable iff (rst)
		tx_rise && tx_enable_strobe |=> !tx_enable_strobe)
		else $error("strobe longer than one link clock");
	a_strobe_addr: assert property (@(posedge mclk) disable iff (rst)
		tx_enable_strobe |-> tx_pins.addr_oe)
		else $error("strobe with address pins released");
	a_addr_oe_mode: assert property (@(posedge mclk) disable iff (rst)
		tx_rise |=> tx_pins.addr_oe == $past(mode_cell && multi_phy))
		else $error("address enable wrong for mode");
	a_poll_walk: assert property (@(posedge mclk) disable iff (rst)
		tx_rise && state == utx_pkg::ST_POLL && mode_cell && multi_phy && !cell_go |=>
			poll_addr == $past(poll_addr) + 5'h01)
		else $error("poll address did not step");
	a_clav_tag: assert property (@(posedge mclk) disable iff (rst)
		tx_rise |=> poll_result.addr == $past(tx_pins.addr))
		else $error("clav sample tied to wrong address");
	a_clav_valid: assert property (@(posedge mclk) disable iff (rst)
		tx_rise |=> poll_result.valid == $past(tx_pins.addr_oe))
		else $error("clav sample valid without polled address");
	a_clav_value: assert property (@(posedge mclk) disable iff (rst)
		tx_rise |=> poll_result.space == $past(clav_sync[1]))
		else $error("clav sample value wrong");
	a_rx_sample: assert property (@(posedge mclk) disable iff (rst)
		rx_rise |=> rx_sample_pulse && rx_sampled == $past(rx_s2))
		else $error("receive inputs not sampled at edge");
	a_rx_hold: assert property (@(posedge mclk) disable iff (rst)
		!rx_rise |=> $stable(rx_sampled))
		else $error("receive sample moved off receive edge");
	a_pulse_one: assert property (@(posedge mclk) disable iff (rst)
		rx_sample_pulse |=> !rx_sample_pulse)
		else $error("receive pulse wider than one clock");

	// =====================================================
	// cover points
	c_select: cover property (@(posedge mclk) disable iff (rst) $rose(tx_enable_strobe));
	c_clav_hi: cover property (@(posedge mclk) disable iff (rst)
		poll_result.valid && poll_result.space);
	c_wrap: cover property (@(posedge mclk) disable iff (rst) tx_pins.addr == utx_pkg::ADDR_LAST);
	c_rx: cover property (@(posedge mclk) disable iff (rst) rx_sample_pulse);
	c_single: cover property (@(posedge mclk) disable iff (rst)
		tx_pins.data_oe && !tx_pins.addr_oe);

endmodule

// [tb/utopia2_tx_poll_rx_clock_bench.sv]
module utopia2_tx_poll_rx_clock_bench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [31:0] READY = 32'h5a3c_96e1;
	logic mclk = 1'b0, rst = 1'b1, mode_cell = 1'b0, multi_phy = 1'b0;
	logic cell_go = 1'b0, cell_done = 1'b0;
	logic [7:0] cell_tx_byte = 8'h00;
	logic [4:0] cell_target = 5'h00;
	logic cell_tx_clock, cell_rx_clock, tx_cell_space_flag, tx_enable_strobe, rx_sample_pulse;
	logic [7:0] rx_pin_bus, rx_sampled;
	utx_pkg::utx_tx_pins_t tx_pins;
	utx_pkg::utx_poll_t    poll_result;
	int err_total = 0;
	int n_compared = 0;
	always #2 mclk = ~mclk;
	utx_port i_utx_port (.mclk(mclk), .rst(rst), .mode_cell(mode_cell), .multi_phy(multi_phy),
		.cell_tx_clock(cell_tx_clock), .cell_rx_clock(cell_rx_clock), .cell_tx_byte(cell_tx_byte),
		.cell_go(cell_go), .cell_target(cell_target), .cell_done(cell_done),
		.tx_cell_space_flag(tx_cell_space_flag), .rx_pin_bus(rx_pin_bus), .tx_pins(tx_pins),
		.tx_enable_strobe(tx_enable_strobe), .poll_result(poll_result),
		.rx_sampled(rx_sampled), .rx_sample_pulse(rx_sample_pulse));
	utx_phy_model #(.READY(READY)) i_utx_phy_model (.cell_tx_clock(cell_tx_clock),
		.cell_rx_clock(cell_rx_clock), .addr(tx_pins.addr), .addr_oe(tx_pins.addr_oe),
		.clav(tx_cell_space_flag), .rx_bus(rx_pin_bus), .mii(!mode_cell));
	// ==========================================
	// shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		if (err_total == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// outputs settle about three mclk after a pin edge, well inside half a link clock
	task automatic wait_tx();
		@(posedge cell_tx_clock);
		repeat (8) @(negedge mclk);
	endtask
	// one receive clock rise: the byte standing at the rise must come up with one pulse
	task automatic rx_capture();
		logic [7:0] exp_rx;
		int         n;
		@(posedge cell_rx_clock);
		exp_rx = rx_pin_bus;
		n = 0;
		@(negedge mclk);
		while (rx_sample_pulse !== 1'b1 && n < 8) begin
			@(negedge mclk);
			n++;
		end
		check(rx_sample_pulse, 1'b1);
		check(rx_sampled, exp_rx);
		@(negedge mclk);
		check(rx_sample_pulse, 1'b0);
	endtask
	// ==========================================
	// scenarios
	task automatic t_reset();
		repeat (12) @(negedge mclk);
		check({tx_pins, tx_enable_strobe, poll_result}, 32'h0);
		check({rx_sampled, rx_sample_pulse}, 32'h0);
		@(posedge mclk) rst <= 1'b0;
	endtask
	task automatic t_poll();
		logic [4:0] prev;
		@(posedge mclk) mode_cell <= 1'b1;
		multi_phy <= 1'b1;
		repeat (3) wait_tx();
		// long enough to walk past the last address and wrap
		for (int i = 0; i < 34; i++) begin
			prev = tx_pins.addr;
			@(posedge mclk) cell_tx_byte <= {i[2:0], 5'h0b};
			wait_tx();
			check(poll_result.addr, prev);
			check(poll_result.valid, 1'b1);
			check(poll_result.space, READY[prev]);
			check(tx_pins.addr, 5'(prev + 5'h01));
			check(tx_pins.addr_oe, 1'b1);
			check(tx_pins.data_oe, 1'b1);
			check(tx_pins.data_hi, i[2:0]);
		end
	endtask
	task automatic t_select();
		@(posedge mclk) cell_target <= 5'h13;
		cell_go <= 1'b1;
		wait_tx();
		@(posedge mclk) cell_go <= 1'b0;
		wait_tx();
		check({tx_enable_strobe, tx_pins.addr}, {1'b1, 5'h13});
		wait_tx();
		check(tx_enable_strobe, 1'b0);
		@(posedge mclk) cell_done <= 1'b1;
		wait_tx();
		@(posedge mclk) cell_done <= 1'b0;
	endtask
	task automatic t_rx();
		repeat (4) rx_capture();
	endtask
	// single-phy cell mode: data pins driven, address pins released, no select
	task automatic t_single();
		@(posedge mclk) multi_phy <= 1'b0;
		cell_go <= 1'b1;
		repeat (3) begin
			wait_tx();
			check(tx_enable_strobe, 1'b0);
			check(tx_pins.addr_oe, 1'b0);
			check(tx_pins.data_oe, 1'b1);
		end
		@(posedge mclk) cell_go <= 1'b0;
	endtask
	// mii mode must ignore a select request even with multi-phy set
	task automatic t_mii();
		@(posedge mclk) mode_cell <= 1'b0;
		multi_phy <= 1'b1;
		cell_go <= 1'b1;
		repeat (3) begin
			wait_tx();
			check(tx_enable_strobe, 1'b0);
			check(tx_pins.addr_oe, 1'b0);
			check(tx_pins.data_oe, 1'b0);
		end
		check(poll_result.valid, 1'b0);
		@(posedge mclk) cell_go <= 1'b0;
		repeat (4) rx_capture();
	endtask
	initial begin
		#40000;
		err_total++;
		close_out();
	end
	initial begin
		t_reset();
		t_poll();
		t_select();
		t_rx();
		t_single();
		t_mii();
		close_out();
	end
endmodule

// [tb/utx_phy_model.sv]
// ==========================================
// phy model: link clocks, cell-space answer, receive data
module utx_phy_model #(
	parameter logic [31:0] READY = 32'h0000_0000
) (
	output logic       cell_tx_clock, // link transmit clock
	output logic       cell_rx_clock, // link receive clock
	input  wire logic [4:0] addr,     // address seen on the pins
	input  wire logic       addr_oe,  // address pins driven
	output logic       clav,          // shared cell-space line
	output logic [7:0] rx_bus,        // receive inputs
	input  wire logic       mii       // mii mode: faster receive clock
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		cell_tx_clock = 1'b0;
		clav = 1'b0;
		rx_bus = 8'h3c;
	end
	always #62.5 cell_tx_clock = ~cell_tx_clock;
	// receive clock: 8 mhz in cell mode, 25 mhz (100 mbps) in mii mode
	initial begin
		cell_rx_clock = 1'b0;
		#31;
		forever #(mii ? 20.0 : 62.5) cell_rx_clock = ~cell_rx_clock;
	end
	// answer mid-cycle so the line is settled at the next rising edge
	always @(negedge cell_tx_clock) begin
		clav <= addr_oe ? READY[addr] : ~clav;
	end
	always @(negedge cell_rx_clock) begin
		rx_bus <= rx_bus + 8'h27;
	end
endmodule
